// file: tpg_pkg.sv
`default_nettype none
// ==========================================
// shared constants for the gate control link
package tpg_pkg;
	localparam int unsigned CLK_FREQ_KHZ = 250000;
	localparam int unsigned TB_FREQ_KHZ  = 17000;
	// time base tick, divider rounds down to the shortest period
	localparam int unsigned TB_DIV_NOM   = CLK_FREQ_KHZ / TB_FREQ_KHZ;
	localparam logic [5:0]  TB_DIV_W     = 6'(TB_DIV_NOM);
	localparam logic [7:0]  DT_MIN       = 8'h01;
	localparam logic [7:0]  DT_RESET     = 8'h10;
	localparam logic [7:0]  BLANK_TB     = 8'h08;
	localparam int unsigned PRECHARGE_NS = 1000;
	localparam int unsigned PRECHARGE_CYC = (PRECHARGE_NS * CLK_FREQ_KHZ) / 1000000;
	localparam logic [9:0]  PRECHARGE_W  = 10'(PRECHARGE_CYC);
	// mode bit positions in set-mode data
	localparam int unsigned MODE_FULL_ON = 0;
	localparam int unsigned MODE_DESAT   = 1;
	localparam int unsigned MODE_ZERO    = 2;
	// read-back selectors
	localparam logic [7:0]  RD_STATUS    = 8'h00;
	localparam logic [7:0]  RD_DEADTIME  = 8'h01;
	localparam logic [7:0]  RD_MASKS     = 8'h02;
	localparam logic [7:0]  RD_CAL       = 8'h03;
	typedef enum logic [3:0] {
		TPG_OP_NOP      = 4'h0,
		TPG_OP_DEADTIME = 4'h1,
		TPG_OP_ZERO_DT  = 4'h2,
		TPG_OP_CAL      = 4'h3,
		TPG_OP_MODE     = 4'h4,
		TPG_OP_LOCK     = 4'h5,
		TPG_OP_ARM      = 4'h6,
		TPG_OP_SIMUL    = 4'h7,
		TPG_OP_REPORT   = 4'h8,
		TPG_OP_INTMASK  = 4'h9,
		TPG_OP_READ     = 4'hA,
		TPG_OP_CLEAR    = 4'hB
	} tpg_op_t;
	typedef enum logic [2:0] {
		TPG_SIM_IDLE  = 3'h1,
		TPG_SIM_ARMED = 3'h2,
		TPG_SIM_DONE  = 3'h4
	} tpg_sim_t;
	typedef enum logic [3:0] {
		TPG_H_IDLE = 4'h1,
		TPG_H_PRE  = 4'h2,
		TPG_H_ARM  = 4'h4,
		TPG_H_SIM  = 4'h8
	} tpg_host_t;
endpackage : tpg_pkg
`default_nettype wire

// file: tpg_link_if.sv
`default_nettype none
// ==========================================
// phase inputs, command port and read-back
interface tpg_link_if;
	logic [2:0] high_side_input;
	logic [2:0] low_side_input;
	logic       cmd_valid;
	tpg_pkg::tpg_op_t cmd_op;
	logic [7:0] cmd_data;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       int_flag;
	modport device (
		input  high_side_input, low_side_input, cmd_valid, cmd_op, cmd_data,
		output rsp_valid, rsp_data, int_flag
	);
	modport host (
		output high_side_input, low_side_input, cmd_valid, cmd_op, cmd_data,
		input  rsp_valid, rsp_data, int_flag
	);
endinterface : tpg_link_if
`default_nettype wire

// file: tpg_device.sv
`default_nettype none
module tpg_device (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// link to the controller
	tpg_link_if.device      link,
	// driver side
	input  wire logic       enable,
	input  wire logic [2:0] desat_in,
	input  wire logic       overcurrent_in,
	output logic      [2:0] gate_hs,
	output logic      [2:0] gate_ls,
	output logic            ilim_blank,
	output logic            fault_blank
);
	// ==========================================
	// configuration state
	logic [7:0]  dt_val, next_dt_val;
	logic [7:0]  cal_trim, next_cal_trim;
	logic [2:0]  modes, next_modes;
	logic        locked, next_locked;
	logic        simul, next_simul;
	logic [3:0]  report_mask, next_report_mask;
	logic [3:0]  int_mask, next_int_mask;
	logic [3:0]  fault, next_fault;
	logic        rsp_valid, next_rsp_valid;
	logic [7:0]  rsp_data, next_rsp_data;
	logic        int_q, next_int_q;
	tpg_pkg::tpg_sim_t sim_st, next_sim_st;
	logic        full_on, zero_gap, desat_mode, shut;
	logic        is_cmd;

	assign full_on    = modes[tpg_pkg::MODE_FULL_ON];
	assign desat_mode = modes[tpg_pkg::MODE_DESAT];
	assign zero_gap   = modes[tpg_pkg::MODE_ZERO];
	// shutdown only when desaturation protection is armed
	assign shut       = desat_mode & (|fault[2:0]);
	assign link.rsp_valid = rsp_valid;
	assign link.rsp_data  = rsp_data;
	assign link.int_flag  = int_q;

	function automatic logic op_is(input tpg_pkg::tpg_op_t op);
		op_is = link.cmd_valid && (link.cmd_op == op);
	endfunction : op_is

	// ==========================================
	// time base divider, trimmed by calibration
	logic [5:0]  tb_cnt, next_tb_cnt;
	logic [5:0]  tb_div;
	logic        tb_tick;
	assign tb_div  = 6'(tpg_pkg::TB_DIV_W + cal_trim[5:0]);
	assign tb_tick = (tb_cnt == 6'h00);

	always_comb begin
		next_tb_cnt = tb_tick ? 6'(tb_div - 6'h01) : 6'(tb_cnt - 6'h01);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tb_cnt <= 6'h00;
		end else begin
			tb_cnt <= next_tb_cnt;
		end
	end

	// ==========================================
	// command decode
	always_comb begin
		is_cmd           = link.cmd_valid;
		next_dt_val      = dt_val;
		next_cal_trim    = cal_trim;
		next_modes       = modes;
		next_locked      = locked;
		next_simul       = simul;
		next_sim_st      = sim_st;
		next_report_mask = report_mask;
		next_int_mask    = int_mask;
		next_rsp_valid   = 1'b0;
		next_rsp_data    = rsp_data;
		// zero is not a counted value, so it becomes the minimum
		if (op_is(tpg_pkg::TPG_OP_DEADTIME)) begin
			next_dt_val = (link.cmd_data < tpg_pkg::DT_MIN) ? tpg_pkg::DT_MIN
				: link.cmd_data;
			if (!locked) begin
				next_modes[tpg_pkg::MODE_ZERO] = 1'b0;
			end
		end
		if (op_is(tpg_pkg::TPG_OP_ZERO_DT) && !locked) begin
			next_modes[tpg_pkg::MODE_ZERO] = 1'b1;
		end
		if (op_is(tpg_pkg::TPG_OP_CAL)) begin
			next_cal_trim = link.cmd_data;
		end
		if (op_is(tpg_pkg::TPG_OP_MODE) && !locked) begin
			next_modes = link.cmd_data[2:0];
		end
		if (op_is(tpg_pkg::TPG_OP_LOCK)) begin
			next_locked = 1'b1;
		end
		if (op_is(tpg_pkg::TPG_OP_REPORT)) begin
			next_report_mask = link.cmd_data[3:0];
		end
		if (op_is(tpg_pkg::TPG_OP_INTMASK)) begin
			next_int_mask = link.cmd_data[3:0];
		end
		// arm must directly precede the one-shot command
		case (sim_st)
			tpg_pkg::TPG_SIM_IDLE: begin
				if (op_is(tpg_pkg::TPG_OP_ARM)) begin
					next_sim_st = tpg_pkg::TPG_SIM_ARMED;
				end
			end
			tpg_pkg::TPG_SIM_ARMED: begin
				if (op_is(tpg_pkg::TPG_OP_SIMUL)) begin
					next_simul  = link.cmd_data[0];
					next_sim_st = tpg_pkg::TPG_SIM_DONE;
				end else if (is_cmd && !op_is(tpg_pkg::TPG_OP_ARM)) begin
					next_sim_st = tpg_pkg::TPG_SIM_IDLE;
				end
			end
			tpg_pkg::TPG_SIM_DONE: begin
				next_sim_st = tpg_pkg::TPG_SIM_DONE;
			end
			default: begin
				next_sim_st = tpg_pkg::TPG_SIM_IDLE;
			end
		endcase
		if (op_is(tpg_pkg::TPG_OP_READ)) begin
			next_rsp_valid = 1'b1;
			case (link.cmd_data)
				tpg_pkg::RD_STATUS:   next_rsp_data = {simul, locked, modes[1:0], fault};
				tpg_pkg::RD_DEADTIME: next_rsp_data = zero_gap ? 8'h00 : dt_val;
				tpg_pkg::RD_MASKS:    next_rsp_data = {int_mask, report_mask};
				tpg_pkg::RD_CAL:      next_rsp_data = cal_trim;
				default:              next_rsp_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dt_val      <= tpg_pkg::DT_RESET;
			cal_trim    <= 8'h00;
			modes       <= 3'h0;
			locked      <= 1'b0;
			simul       <= 1'b0;
			sim_st      <= tpg_pkg::TPG_SIM_IDLE;
			report_mask <= 4'hF;
			int_mask    <= 4'h0;
			rsp_valid   <= 1'b0;
			rsp_data    <= 8'h00;
		end else begin
			dt_val      <= next_dt_val;
			cal_trim    <= next_cal_trim;
			modes       <= next_modes;
			locked      <= next_locked;
			simul       <= next_simul;
			sim_st      <= next_sim_st;
			report_mask <= next_report_mask;
			int_mask    <= next_int_mask;
			rsp_valid   <= next_rsp_valid;
			rsp_data    <= next_rsp_data;
		end
	end

	// ==========================================
	// per phase edge detect, dead time and decision
	logic [2:0] hs_d, ls_d, want_hs, want_ls, dec_hs, dec_ls, ls_seen;
	logic [2:0] next_want_hs, next_want_ls, next_dec_hs, next_dec_ls, next_ls_seen;
	logic [2:0] next_gate_hs, next_gate_ls, in_edge;
	logic [7:0] dt_cnt [3];
	logic [7:0] next_dt_cnt [3];

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			logic hs_rise, hs_fall, ls_rise, ls_fall;
			assign hs_rise = link.high_side_input[p] & ~hs_d[p];
			assign hs_fall = ~link.high_side_input[p] & hs_d[p];
			assign ls_rise = link.low_side_input[p] & ~ls_d[p];
			assign ls_fall = ~link.low_side_input[p] & ls_d[p];
			assign in_edge[p] = hs_rise | hs_fall | ls_rise | ls_fall;

			always_comb begin
				// a leading edge selects its side and, unless simul is set, drops the other
				next_want_hs[p] = want_hs[p];
				next_want_ls[p] = want_ls[p];
				if (hs_rise) begin
					next_want_hs[p] = 1'b1;
				end else if (hs_fall || (ls_rise && !simul)) begin
					next_want_hs[p] = 1'b0;
				end
				if (ls_rise) begin
					next_want_ls[p] = 1'b1;
				end else if (ls_fall || (hs_rise && !simul)) begin
					next_want_ls[p] = 1'b0;
				end
				// unless simul is set, on only once the timer is out and the partner is off
				// two leading edges in one cycle with simul clear: low side wins, no overlap
				next_dec_ls[p] = enable && !shut && next_want_ls[p]
					&& (simul || (dt_cnt[p] == 8'h00 && !dec_hs[p]));
				next_dec_hs[p] = enable && !shut && next_want_hs[p] && ls_seen[p]
					&& (simul || (dt_cnt[p] == 8'h00 && !dec_ls[p]
					&& !next_dec_ls[p]));
				next_ls_seen[p] = enable && (ls_seen[p] || dec_ls[p]);
				// every turn-off restarts this phase's timer
				if ((dec_hs[p] && !next_dec_hs[p]) || (dec_ls[p] && !next_dec_ls[p])) begin
					next_dt_cnt[p] = zero_gap ? 8'h00 : dt_val;
				end else if (tb_tick && dt_cnt[p] != 8'h00) begin
					next_dt_cnt[p] = 8'(dt_cnt[p] - 8'h01);
				end else begin
					next_dt_cnt[p] = dt_cnt[p];
				end
				// full-on takes the decision straight to the gate
				next_gate_hs[p] = full_on ? next_dec_hs[p] : dec_hs[p];
				next_gate_ls[p] = full_on ? next_dec_ls[p] : dec_ls[p];
			end

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					dt_cnt[p] <= 8'h00;
				end else begin
					dt_cnt[p] <= next_dt_cnt[p];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hs_d    <= 3'h0;
			ls_d    <= 3'h0;
			want_hs <= 3'h0;
			want_ls <= 3'h0;
			dec_hs  <= 3'h0;
			dec_ls  <= 3'h0;
			ls_seen <= 3'h0;
			gate_hs <= 3'h0;
			gate_ls <= 3'h0;
		end else begin
			hs_d    <= link.high_side_input;
			ls_d    <= link.low_side_input;
			want_hs <= next_want_hs;
			want_ls <= next_want_ls;
			dec_hs  <= next_dec_hs;
			dec_ls  <= next_dec_ls;
			ls_seen <= next_ls_seen;
			gate_hs <= next_gate_hs;
			gate_ls <= next_gate_ls;
		end
	end

	// ==========================================
	// blanking and fault capture
	logic [7:0] blank_cnt, next_blank_cnt;
	logic       next_fault_blank, next_ilim_blank, turn_on;
	assign turn_on = |((next_gate_hs & ~gate_hs) | (next_gate_ls & ~gate_ls));

	always_comb begin
		// one shared window covers all phases at once
		if (!simul && (turn_on || (|in_edge))) begin
			next_blank_cnt = tpg_pkg::BLANK_TB;
		end else if (tb_tick && blank_cnt != 8'h00) begin
			next_blank_cnt = 8'(blank_cnt - 8'h01);
		end else begin
			next_blank_cnt = blank_cnt;
		end
		next_fault_blank = (next_blank_cnt != 8'h00);
		next_ilim_blank  = (next_blank_cnt != 8'h00);
		// a new event wins over a clear in the same cycle
		next_fault = fault;
		if (op_is(tpg_pkg::TPG_OP_CLEAR)) begin
			next_fault = fault & ~link.cmd_data[3:0];
		end
		next_fault = next_fault | (report_mask
			& {overcurrent_in, desat_in & gate_hs} & {4{!fault_blank}});
		next_int_q = |(fault & int_mask);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			blank_cnt   <= 8'h00;
			fault_blank <= 1'b0;
			ilim_blank  <= 1'b0;
			fault       <= 4'h0;
			int_q       <= 1'b0;
		end else begin
			blank_cnt   <= next_blank_cnt;
			fault_blank <= next_fault_blank;
			ilim_blank  <= next_ilim_blank;
			fault       <= next_fault;
			int_q       <= next_int_q;
		end
	end
endmodule : tpg_device
`default_nettype wire

// file: tpg_host.sv
`default_nettype none
module tpg_host (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// link to the predriver
	tpg_link_if.host        link,
	// user side
	input  wire logic [2:0] usr_hs,
	input  wire logic [2:0] usr_ls,
	input  wire logic       usr_precharge,
	input  wire logic       usr_cmd_valid,
	input  wire logic [3:0] usr_cmd_op,
	input  wire logic [7:0] usr_cmd_data,
	input  wire logic       usr_simul_req,
	input  wire logic       usr_simul_on,
	output logic            usr_busy,
	output logic            usr_rsp_valid,
	output logic      [7:0] usr_rsp_data,
	output logic            usr_int
);
	// ==========================================
	// sequencer for precharge and the arm sequence
	tpg_pkg::tpg_host_t st, next_st;
	logic [9:0] pre_cnt, next_pre_cnt;
	logic [2:0] hs_q, ls_q, next_hs_q, next_ls_q;
	logic       cv_q, next_cv_q, next_busy, sim_val, next_sim_val;
	tpg_pkg::tpg_op_t op_q, next_op_q;
	logic [7:0] data_q, next_data_q;

	assign link.high_side_input = hs_q;
	assign link.low_side_input  = ls_q;
	assign link.cmd_valid       = cv_q;
	assign link.cmd_op          = op_q;
	assign link.cmd_data        = data_q;

	always_comb begin
		next_st      = st;
		next_pre_cnt = pre_cnt;
		next_sim_val = sim_val;
		next_hs_q    = usr_hs;
		next_ls_q    = usr_ls;
		next_cv_q    = usr_cmd_valid;
		next_op_q    = tpg_pkg::tpg_op_t'(usr_cmd_op);
		next_data_q  = usr_cmd_data;
		case (st)
			tpg_pkg::TPG_H_IDLE: begin
				if (usr_precharge) begin
					next_st      = tpg_pkg::TPG_H_PRE;
					next_pre_cnt = tpg_pkg::PRECHARGE_W;
				end else if (usr_simul_req) begin
					next_st      = tpg_pkg::TPG_H_ARM;
					next_sim_val = usr_simul_on;
				end
			end
			tpg_pkg::TPG_H_PRE: begin
				// low sides on, high sides held off to charge bootstrap
				next_hs_q    = 3'h0;
				next_ls_q    = 3'h7;
				next_pre_cnt = 10'(pre_cnt - 10'h001);
				if (pre_cnt == 10'h000) begin
					next_ls_q = 3'h0;
					next_st   = tpg_pkg::TPG_H_IDLE;
				end
			end
			tpg_pkg::TPG_H_ARM: begin
				next_cv_q   = 1'b1;
				next_op_q   = tpg_pkg::TPG_OP_ARM;
				next_data_q = 8'h00;
				next_st     = tpg_pkg::TPG_H_SIM;
			end
			tpg_pkg::TPG_H_SIM: begin
				next_cv_q   = 1'b1;
				next_op_q   = tpg_pkg::TPG_OP_SIMUL;
				next_data_q = {7'h00, sim_val};
				next_st     = tpg_pkg::TPG_H_IDLE;
			end
			default: begin
				next_st = tpg_pkg::TPG_H_IDLE;
			end
		endcase
		// user commands are dropped while the sequencer owns the port
		if (st != tpg_pkg::TPG_H_IDLE && st != tpg_pkg::TPG_H_PRE) begin
			next_cv_q = (st == tpg_pkg::TPG_H_ARM) || (st == tpg_pkg::TPG_H_SIM);
		end
		next_busy = (next_st != tpg_pkg::TPG_H_IDLE);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st            <= tpg_pkg::TPG_H_IDLE;
			pre_cnt       <= 10'h000;
			sim_val       <= 1'b0;
			hs_q          <= 3'h0;
			ls_q          <= 3'h0;
			cv_q          <= 1'b0;
			op_q          <= tpg_pkg::TPG_OP_NOP;
			data_q        <= 8'h00;
			usr_busy      <= 1'b0;
			usr_rsp_valid <= 1'b0;
			usr_rsp_data  <= 8'h00;
			usr_int       <= 1'b0;
		end else begin
			st            <= next_st;
			pre_cnt       <= next_pre_cnt;
			sim_val       <= next_sim_val;
			hs_q          <= next_hs_q;
			ls_q          <= next_ls_q;
			cv_q          <= next_cv_q;
			op_q          <= next_op_q;
			data_q        <= next_data_q;
			usr_busy      <= next_busy;
			usr_rsp_valid <= link.rsp_valid;
			usr_rsp_data  <= link.rsp_valid ? link.rsp_data : usr_rsp_data;
			usr_int       <= link.int_flag;
		end
	end
endmodule : tpg_host
`default_nettype wire

// file: tpg_monitor.sv
`default_nettype none
// ==========================================
// link and gate checker
module tpg_monitor (
	// clock and reset
	input wire logic             clk,
	input wire logic             sys_rst,
	// link
	input wire logic [2:0]       high_side_input,
	input wire logic [2:0]       low_side_input,
	input wire logic             cmd_valid,
	input wire tpg_pkg::tpg_op_t cmd_op,
	input wire logic             rsp_valid,
	// driver side
	input wire logic             enable,
	input wire logic [2:0]       gate_hs,
	input wire logic [2:0]       gate_ls,
	input wire logic             ilim_blank,
	input wire logic             fault_blank
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic       is_read;
	logic [2:0] ls_seen;
	logic [2:0] next_ls_seen;

	// a read request on the command port
	assign is_read = cmd_valid && (cmd_op == tpg_pkg::TPG_OP_READ);

	// low side seen since enable; dropping enable forgets it
	always_comb begin
		next_ls_seen = (sys_rst || !enable) ? 3'h0 : (ls_seen | gate_ls);
	end
	always_ff @(posedge clk) begin
		ls_seen <= next_ls_seen;
	end

	// ==========================================
	// edge events on phase 0
	sequence ls_lead;
		$rose(low_side_input[0]);
	endsequence
	sequence hs_lead;
		$rose(high_side_input[0]);
	endsequence

	// ==========================================
	// assertions
	read_answer_a: assert property (is_read |=> rsp_valid)
		else $error("read got no answer");
	answer_cause_a: assert property (rsp_valid |-> $past(is_read))
		else $error("answer without read");
	no_overlap_a: assert property ((gate_hs & gate_ls) == 3'h0)
		else $error("both gates of a phase on");
	hs_after_ls_a: assert property ((gate_hs & ~$past(gate_hs) & ~ls_seen) == 3'h0)
		else $error("high side before low side");
	reset_off_a: assert property (disable iff (1'b0)
		sys_rst |=> (gate_hs == 3'h0) && (gate_ls == 3'h0) && !rsp_valid)
		else $error("outputs live after reset");
	ls_drops_hs_a: assert property (ls_lead |-> ##[1:2] !gate_hs[0])
		else $error("high side kept on");
	hs_drops_ls_a: assert property (hs_lead |-> ##[1:2] !gate_ls[0])
		else $error("low side kept on");
	edge_blank_a: assert property ($changed(low_side_input) |-> ##[1:3] ilim_blank)
		else $error("no current limit blanking");
	turnon_blank_a: assert property (
		((gate_hs | gate_ls) & ~$past(gate_hs | gate_ls)) != 3'h0 |-> ##[0:2] fault_blank)
		else $error("no fault blanking");
endmodule : tpg_monitor
`default_nettype wire

// file: tpg_test.sv
`default_nettype none
// ==========================================
// host and predriver back to back
module tpg_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DT_CYC = int'(tpg_pkg::DT_RESET) * tpg_pkg::TB_DIV_NOM;

	logic       clk;
	logic       sys_rst;
	logic       enable;
	logic       ovc;
	logic [2:0] desat;
	logic [2:0] gate_hs;
	logic [2:0] gate_ls;
	logic       ilim_blank;
	logic       fault_blank;
	logic [2:0] usr_hs;
	logic [2:0] usr_ls;
	logic       usr_precharge;
	logic       usr_cmd_valid;
	logic [3:0] usr_cmd_op;
	logic [7:0] usr_cmd_data;
	logic       usr_simul_req;
	logic       usr_simul_on;
	logic       usr_busy;
	logic       usr_rsp_valid;
	logic [7:0] usr_rsp_data;
	logic       usr_int;
	logic [5:0] gates;
	int         fails;
	int         samples_checked;
	int         c;

`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("BAD at %0t got %h exp %h", $time, got, exp); \
	end \
end

	assign gates = {gate_hs, gate_ls};
	tpg_link_if link ();

	tpg_device i_tpg_device (.clk(clk), .sys_rst(sys_rst), .link(link.device),
		.enable(enable), .desat_in(desat), .overcurrent_in(ovc), .gate_hs(gate_hs),
		.gate_ls(gate_ls), .ilim_blank(ilim_blank), .fault_blank(fault_blank));
	tpg_host i_tpg_host (.clk(clk), .sys_rst(sys_rst), .link(link.host), .usr_hs(usr_hs),
		.usr_ls(usr_ls), .usr_precharge(usr_precharge), .usr_cmd_valid(usr_cmd_valid),
		.usr_cmd_op(usr_cmd_op), .usr_cmd_data(usr_cmd_data), .usr_simul_req(usr_simul_req),
		.usr_simul_on(usr_simul_on), .usr_busy(usr_busy), .usr_rsp_valid(usr_rsp_valid),
		.usr_rsp_data(usr_rsp_data), .usr_int(usr_int));
	tpg_monitor i_tpg_monitor (.clk(clk), .sys_rst(sys_rst),
		.high_side_input(link.high_side_input), .low_side_input(link.low_side_input),
		.cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .rsp_valid(link.rsp_valid),
		.enable(enable), .gate_hs(gate_hs), .gate_ls(gate_ls),
		.ilim_blank(ilim_blank), .fault_blank(fault_blank));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================
	// access tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// sync reset, held long so every counter settles
	task automatic do_reset();
		sys_rst = 1'b1;
		tick(20);
		sys_rst = 1'b0;
	endtask : do_reset

	task automatic send(input tpg_pkg::tpg_op_t op, input logic [7:0] d);
		usr_cmd_op = op;
		usr_cmd_data = d;
		usr_cmd_valid = 1'b1;
		tick(1);
		usr_cmd_valid = 1'b0;
		tick(2);
	endtask : send

	// read-back answer is a one-cycle pulse, so poll every cycle
	task automatic chk_rd(input logic [7:0] sel, input logic [7:0] exp);
		send(tpg_pkg::TPG_OP_READ, sel);
		for (c = 0; c < 10 && usr_rsp_valid !== 1'b1; c++)
			tick(1);
		if (c == 10) begin
			fails++;
			finish_test();
		end
		`CHK(usr_rsp_data, exp)
		tick(1);
	endtask : chk_rd

	task automatic simul(input logic on);
		usr_simul_on = on;
		usr_simul_req = 1'b1;
		tick(1);
		usr_simul_req = 1'b0;
		tick(6);
	endtask : simul

	task automatic wait_gate(input int b, input int lim);
		for (c = 0; c < lim && gates[b] !== 1'b1; c++)
			tick(1);
		if (c == lim) begin
			fails++;
			finish_test();
		end
	endtask : wait_gate

	// ==========================================
	// main sequence
	initial begin
		{sys_rst, enable, ovc, usr_hs, usr_ls, usr_precharge} = 10'h200;
		{usr_cmd_valid, usr_cmd_op, usr_cmd_data} = 13'h0000;
		{usr_simul_req, usr_simul_on} = 2'h0;
		desat = 3'h0;
		fails = 0;
		samples_checked = 0;
		do_reset();
		chk_rd(tpg_pkg::RD_DEADTIME, tpg_pkg::DT_RESET);
		chk_rd(tpg_pkg::RD_MASKS, 8'h0F);
		chk_rd(tpg_pkg::RD_CAL, 8'h00);
		send(tpg_pkg::TPG_OP_DEADTIME, 8'h00);
		chk_rd(tpg_pkg::RD_DEADTIME, tpg_pkg::DT_MIN);
		send(tpg_pkg::TPG_OP_DEADTIME, 8'hFF);
		chk_rd(tpg_pkg::RD_DEADTIME, 8'hFF);
		send(tpg_pkg::TPG_OP_ZERO_DT, 8'h00);
		chk_rd(tpg_pkg::RD_DEADTIME, 8'h00);
		send(tpg_pkg::TPG_OP_DEADTIME, 8'h05);
		chk_rd(tpg_pkg::RD_DEADTIME, 8'h05);
		send(tpg_pkg::TPG_OP_CAL, 8'h03);
		chk_rd(tpg_pkg::RD_CAL, 8'h03);
		send(tpg_pkg::TPG_OP_MODE, 8'h01);
		chk_rd(tpg_pkg::RD_STATUS, 8'h10);
		send(tpg_pkg::TPG_OP_LOCK, 8'h00);
		send(tpg_pkg::TPG_OP_MODE, 8'h00);
		send(tpg_pkg::TPG_OP_ZERO_DT, 8'h00);
		chk_rd(tpg_pkg::RD_STATUS, 8'h50);
		chk_rd(tpg_pkg::RD_DEADTIME, 8'h05);
		$display("modes done");
		// simultaneous conduction: needs arming, taken once
		do_reset();
		chk_rd(tpg_pkg::RD_STATUS, 8'h00);
		send(tpg_pkg::TPG_OP_SIMUL, 8'h01);
		chk_rd(tpg_pkg::RD_STATUS, 8'h00);
		simul(1'b1);
		simul(1'b0);
		chk_rd(tpg_pkg::RD_STATUS, 8'h80);
		$display("simul done");
		// overcurrent fault reporting and interrupt
		do_reset();
		ovc = 1'b1;
		tick(4);
		chk_rd(tpg_pkg::RD_STATUS, 8'h08);
		`CHK(usr_int, 1'b0)
		send(tpg_pkg::TPG_OP_INTMASK, 8'h08);
		chk_rd(tpg_pkg::RD_MASKS, 8'h8F);
		`CHK(usr_int, 1'b1)
		send(tpg_pkg::TPG_OP_REPORT, 8'h00);
		send(tpg_pkg::TPG_OP_CLEAR, 8'h08);
		chk_rd(tpg_pkg::RD_STATUS, 8'h00);
		tick(3);
		`CHK(usr_int, 1'b0)
		ovc = 1'b0;
		$display("faults done");
		// gate sequencing from a fresh reset
		do_reset();
		enable = 1'b1;
		usr_hs = 3'h1;
		tick(300);
		`CHK(gate_hs, 3'h0)
		usr_hs = 3'h0;
		usr_precharge = 1'b1;
		tick(1);
		usr_precharge = 1'b0;
		tick(3);
		`CHK(usr_busy, 1'b1)
		tick(600);
		`CHK(usr_busy, 1'b0)
		usr_ls = 3'h1;
		wait_gate(0, 20);
		`CHK(c <= 3, 1'b1)
		// low side input stays high, only the edge counts
		usr_hs = 3'h1;
		wait_gate(3, 400);
		`CHK(gate_ls[0], 1'b0)
		`CHK(c >= DT_CYC - tpg_pkg::TB_DIV_NOM, 1'b1)
		`CHK(c <= DT_CYC + tpg_pkg::TB_DIV_NOM + 4, 1'b1)
		usr_hs = 3'h0;
		tick(300);
		usr_ls = 3'h0;
		tick(1);
		usr_ls = 3'h1;
		wait_gate(0, 20);
		`CHK(c <= 3, 1'b1)
		$display("gates done");
		// full-on, zero gap and desaturation shutdown on live gates
		usr_ls = 3'h0;
		do_reset();
		send(tpg_pkg::TPG_OP_MODE, 8'h07);
		usr_ls = 3'h1;
		wait_gate(0, 20);
		`CHK(c <= 2, 1'b1)
		usr_hs = 3'h1;
		wait_gate(3, 20);
		`CHK(c <= 3, 1'b1)
		// fault is only taken once the blanking window has run out
		desat = 3'h1;
		tick(150);
		`CHK(gate_hs, 3'h0)
		chk_rd(tpg_pkg::RD_STATUS, 8'h31);
		desat = 3'h0;
		$display("full on done");
		finish_test();
	end
endmodule : tpg_test
`default_nettype wire
